// ---- hw/uafd_top.sv ----
// Purpose: UART channel data path with FIFOs and RTS/CTS flow control
// Assumes: baud_tick is a one-cycle pulse at the oversampling rate
// Notes:   Registers over AHB-Lite, zero wait states
// Notes on behaviour
// - Holding byte framed with start, parity, stop
// - Data leaves least significant bit first
// - FIFO mode writes fill sixteen-byte queue
// - Non-FIFO: holding empty set on transfer
// - Non-FIFO: empty interrupt needs enable bit one
// - Transmitter empty needs shifter and FIFO empty
// - FIFO mode: holding empty when FIFO empty
// - FIFO mode: interrupt below transmit trigger
// - Start bit validated at half bit
// - Every bit sampled at its centre
// - Receive entries carry three error tags
// - Read pops, new head tags shown
// - Receive interrupt per character or trigger
// - Timeout after four characters plus twelve
// - Auto RTS needs feature and RTS bit
// - RTS rising flags and interrupts if enabled
// - RTS deasserted at upper fill level
// - RTS reasserted at lower fill level
// - Receiver keeps filling until full
// - Auto CTS pauses after current stop bit
// - CTS going high flags and interrupts
// - Bit time is 16, 8 or 4 ticks
module uafd_top #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        baud_tick,
  input  wire logic        rxd,
  input  wire logic        cts_n,
  output logic             txd,
  output logic             rts_n,
  output logic             irq
);
  localparam int CW = AW + 1;

  if (DEPTH != (1 << AW) || DEPTH < 16)
  begin : g_bad_depth
    $error("DEPTH must equal 2**AW and be at least 16");
  end

  logic [7:0] int_en, fifo_ctl, line_ctl, modem_ctl, enh_feat, frac_div;
  logic          wr_pend;
  logic [7:0]    wr_addr;
  logic [CW-1:0] tx_cnt, rx_cnt;
  logic [AW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [7:0]    tx_q;
  logic [10:0]   rx_q;
  logic          rx_m, rx_s, rx_d, cts_m, cts_s, cts_d;
  uafd_pkg::uafd_ser_t tx_state, rx_state;
  logic [4:0]    tx_tick, rx_tick;
  logic [7:0]    tx_shift, rx_data;
  logic [2:0]    tx_idx, rx_idx;
  logic          tx_par, tx_stop2, rx_perr, rx_one, overrun;
  logic [10:0]   tout_cnt;
  logic          tout_flag, thr_pend, thr_cond_d, flow_pend;
  logic [7:0]    isr_val, lsr_val;

  // Bus decode and derived controls
  wire        addr_ok  = hsel & htrans[1] & hready;
  wire        rd_now   = addr_ok & ~hwrite;
  wire [7:0]  a_off    = haddr[7:0];
  wire        fifo_en  = fifo_ctl[uafd_pkg::FC_EN];
  wire [CW-1:0] cap    = fifo_en ? CW'(DEPTH) : CW'(1);
  wire        tx_full  = tx_cnt >= cap;
  wire        rx_full  = rx_cnt >= cap;
  wire [4:0]  os       = uafd_pkg::OS_TICKS[frac_div[5:4]];
  wire [4:0]  half_m1  = (os >> 1) - 5'h01;
  wire [4:0]  os_m1    = os - 5'h01;
  wire [2:0]  nbits_m1 = 3'(uafd_pkg::MIN_BITS - 1) + {1'b0, line_ctl[1:0]};
  wire        par_en   = line_ctl[uafd_pkg::LC_PAR];
  wire        par_even = line_ctl[uafd_pkg::LC_EVEN];
  wire        tx_push  = wr_pend & (wr_addr == uafd_pkg::ADDR_DATA) & ~tx_full;
  wire        rx_pop   = rd_now & (a_off == uafd_pkg::ADDR_DATA) &
                         (rx_cnt != '0);
  wire        isr_rd   = rd_now & (a_off == uafd_pkg::ADDR_INT_ST);
  wire        lsr_rd   = rd_now & (a_off == uafd_pkg::ADDR_LSTAT);
  wire        fc_wr    = wr_pend & (wr_addr == uafd_pkg::ADDR_FIFO);
  wire        tx_bit   = baud_tick & (tx_tick == os_m1);
  wire        rx_half  = baud_tick & (rx_tick == half_m1);
  wire        rx_cent  = baud_tick & (rx_tick == os_m1);
  wire        cts_hold = enh_feat[uafd_pkg::EF_ACTS] & cts_s;
  wire        last_stop = (tx_state == uafd_pkg::S_STOP) & tx_bit &
                          ~tx_stop2;
  // load straight after final stop bit
  wire        tx_load  = ((tx_state == uafd_pkg::S_IDLE & baud_tick) |
                          last_stop) & (tx_cnt != '0) & ~cts_hold;
  wire        rx_end   = (rx_state == uafd_pkg::S_STOP) & rx_cent;
  // accept until full, regardless of RTS
  wire        rx_push  = rx_end & ~rx_full;
  wire [7:0]  tx_mask  = 8'hFF >> (3'h7 - nbits_m1);
  wire [4:0]  rx_trig  = uafd_pkg::TRIG_LVL[fifo_ctl[7:6]];
  wire [4:0]  tx_trig  = uafd_pkg::TRIG_LVL[fifo_ctl[5:4]];
  // holding empty whenever queue holds nothing
  wire        thre     = (tx_cnt == '0);
  wire        temt     = thre & (tx_state == uafd_pkg::S_IDLE);
  // per character or at trigger level
  wire        rx_lvl   = fifo_en ? (rx_cnt >= CW'(rx_trig)) :
                                   (rx_cnt != '0);
  // below trigger in FIFO mode, empty otherwise
  wire        thr_cond = fifo_en ? (tx_cnt < CW'(tx_trig)) : thre;
  wire        rts_auto = enh_feat[uafd_pkg::EF_ARTS] &
                         modem_ctl[uafd_pkg::MC_RTS];
  wire [CW-1:0] rts_hi = CW'(uafd_pkg::RTS_HI[fifo_ctl[7:6]]);
  wire [CW-1:0] rts_lo = CW'(uafd_pkg::RTS_LO[fifo_ctl[7:6]]);
  wire [10:0] char_len = 11'h001 + 11'(nbits_m1) + 11'h001 +
                         11'(par_en) + 11'h001 +
                         11'(line_ctl[uafd_pkg::LC_STOP2]);
  // four characters plus twelve bit times
  wire [10:0] tout_lim = (uafd_pkg::TOUT_CHARS * char_len +
                          uafd_pkg::TOUT_BITS) * 11'(os);
  // read ahead so the new head stands with the pop
  wire [AW-1:0] rx_ra  = rx_pop ? rx_rp + AW'(1) : rx_rp;
  logic next_rts_n;

  uafd_mem #(.WIDTH(8), .AW(AW)) u_tx_mem (
    .clk   (clk),
    .we    (tx_push),
    .waddr (tx_wp),
    .wdata (hwdata[7:0]),
    .raddr (tx_rp),
    .rdata (tx_q)
  );

  // data plus break, framing, parity tags
  uafd_mem #(.WIDTH(11), .AW(AW)) u_rx_mem (
    .clk   (clk),
    .we    (rx_push),
    .waddr (rx_wp),
    .wdata ({~rx_one & ~rx_s, ~rx_s, rx_perr, rx_data}),
    .raddr (rx_ra),
    .rdata (rx_q)
  );

  // Write data lands in the data phase
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= addr_ok & hwrite;
      wr_addr <= a_off;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      int_en    <= uafd_pkg::REG_RESET;
      fifo_ctl  <= uafd_pkg::REG_RESET;
      line_ctl  <= uafd_pkg::REG_RESET;
      modem_ctl <= uafd_pkg::REG_RESET;
      enh_feat  <= uafd_pkg::REG_RESET;
      frac_div  <= uafd_pkg::REG_RESET;
    end
    else if (wr_pend)
    begin
      case (wr_addr)
        uafd_pkg::ADDR_INT_EN: int_en    <= hwdata[7:0];
        uafd_pkg::ADDR_FIFO:   fifo_ctl  <= hwdata[7:0];
        uafd_pkg::ADDR_LINE:   line_ctl  <= hwdata[7:0];
        uafd_pkg::ADDR_MODEM:  modem_ctl <= hwdata[7:0];
        uafd_pkg::ADDR_ENH:    enh_feat  <= hwdata[7:0];
        uafd_pkg::ADDR_FRAC:   frac_div  <= hwdata[7:0];
        default:               int_en    <= int_en;
      endcase
    end
  end

  // head tags follow the pointer at once
  assign lsr_val = {1'b0, temt, thre,
                    (rx_cnt != '0) ? rx_q[10:8] : 3'h0,
                    overrun, rx_cnt != '0};

  always_comb
  begin
    if (int_en[uafd_pkg::IE_RX] && tout_flag)
      isr_val = uafd_pkg::IS_TIMEOUT;
    else if (int_en[uafd_pkg::IE_RX] && rx_lvl)
      isr_val = uafd_pkg::IS_RXRDY;
    else if (int_en[uafd_pkg::IE_THR] && thr_pend)
      isr_val = uafd_pkg::IS_THRE;
    else if (flow_pend)
      isr_val = uafd_pkg::IS_FLOW;
    else
      isr_val = uafd_pkg::IS_NONE;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else if (rd_now)
    begin
      case (a_off)
        uafd_pkg::ADDR_DATA:
          hrdata <= {24'h000000, (rx_cnt != '0) ? rx_q[7:0] : 8'h00};
        uafd_pkg::ADDR_INT_EN: hrdata <= {24'h000000, int_en};
        uafd_pkg::ADDR_INT_ST: hrdata <= {24'h000000, isr_val};
        uafd_pkg::ADDR_FIFO:   hrdata <= {24'h000000, fifo_ctl};
        uafd_pkg::ADDR_LINE:   hrdata <= {24'h000000, line_ctl};
        uafd_pkg::ADDR_MODEM:  hrdata <= {24'h000000, modem_ctl};
        uafd_pkg::ADDR_LSTAT:  hrdata <= {24'h000000, lsr_val};
        uafd_pkg::ADDR_ENH:    hrdata <= {24'h000000, enh_feat};
        uafd_pkg::ADDR_FRAC:   hrdata <= {24'h000000, frac_div};
        default:               hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // pointer steps on every accepted write
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_wp  <= '0;
      tx_rp  <= '0;
      tx_cnt <= '0;
    end
    else if (fc_wr && hwdata[uafd_pkg::FC_TXRST])
    begin
      tx_wp  <= '0;
      tx_rp  <= '0;
      tx_cnt <= '0;
    end
    else
    begin
      if (tx_push)
        tx_wp <= tx_wp + AW'(1);
      if (tx_load)
        tx_rp <= tx_rp + AW'(1);
      if (tx_push && !tx_load)
        tx_cnt <= tx_cnt + CW'(1);
      else if (!tx_push && tx_load)
        tx_cnt <= tx_cnt - CW'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_wp  <= '0;
      rx_rp  <= '0;
      rx_cnt <= '0;
    end
    else if (fc_wr && hwdata[uafd_pkg::FC_RXRST])
    begin
      rx_wp  <= '0;
      rx_rp  <= '0;
      rx_cnt <= '0;
    end
    else
    begin
      if (rx_push)
        rx_wp <= rx_wp + AW'(1);
      if (rx_pop)
        rx_rp <= rx_rp + AW'(1);
      if (rx_push && !rx_pop)
        rx_cnt <= rx_cnt + CW'(1);
      else if (!rx_push && rx_pop)
        rx_cnt <= rx_cnt - CW'(1);
    end
  end

  // Pins are asynchronous, two stages before use
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {rx_m, rx_s, rx_d}    <= 3'h7;
      {cts_m, cts_s, cts_d} <= 3'h7;
    end
    else
    begin
      {rx_m, rx_s, rx_d}    <= {rxd, rx_m, rx_s};
      {cts_m, cts_s, cts_d} <= {cts_n, cts_m, cts_s};
    end
  end

  // framed, LSB first, one bit per os ticks
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_state <= uafd_pkg::S_IDLE;
      tx_tick  <= 5'h00;
      tx_shift <= 8'h00;
      tx_idx   <= 3'h0;
      tx_par   <= 1'b0;
      tx_stop2 <= 1'b0;
      txd      <= 1'b1;
    end
    else if (tx_load)
    begin
      tx_state <= uafd_pkg::S_START;
      tx_tick  <= 5'h00;
      tx_shift <= tx_q & tx_mask;
      tx_par   <= uafd_pkg::uafd_parity(tx_q & tx_mask, par_even);
      txd      <= 1'b0;
    end
    else if (tx_state != uafd_pkg::S_IDLE && baud_tick)
    begin
      tx_tick <= tx_bit ? 5'h00 : tx_tick + 5'h01;
      if (tx_bit)
      begin
        case (tx_state)
          uafd_pkg::S_START:
          begin
            tx_state <= uafd_pkg::S_DATA;
            tx_idx   <= 3'h0;
            txd      <= tx_shift[0];
          end
          uafd_pkg::S_DATA:
          begin
            tx_shift <= tx_shift >> 1;
            tx_idx   <= tx_idx + 3'h1;
            if (tx_idx != nbits_m1)
              txd <= tx_shift[1];
            else if (par_en)
            begin
              tx_state <= uafd_pkg::S_PAR;
              txd      <= tx_par;
            end
            else
            begin
              tx_state <= uafd_pkg::S_STOP;
              tx_stop2 <= line_ctl[uafd_pkg::LC_STOP2];
              txd      <= 1'b1;
            end
          end
          uafd_pkg::S_PAR:
          begin
            tx_state <= uafd_pkg::S_STOP;
            tx_stop2 <= line_ctl[uafd_pkg::LC_STOP2];
            txd      <= 1'b1;
          end
          uafd_pkg::S_STOP:
          begin
            tx_stop2 <= 1'b0;
            if (!tx_stop2)
              tx_state <= uafd_pkg::S_IDLE;
          end
          default: tx_state <= uafd_pkg::S_IDLE;
        endcase
      end
    end
  end

  // validate start at half bit, sample at centres
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_state <= uafd_pkg::S_IDLE;
      rx_tick  <= 5'h00;
      rx_data  <= 8'h00;
      rx_idx   <= 3'h0;
      rx_perr  <= 1'b0;
      rx_one   <= 1'b0;
    end
    else
    begin
      case (rx_state)
        uafd_pkg::S_IDLE:
          if (rx_d && !rx_s)
          begin
            rx_state <= uafd_pkg::S_START;
            rx_tick  <= 5'h00;
          end
        uafd_pkg::S_START:
          if (rx_half)
          begin
            rx_state <= rx_s ? uafd_pkg::S_IDLE : uafd_pkg::S_DATA;
            rx_tick  <= 5'h00;
            rx_idx   <= 3'h0;
            rx_data  <= 8'h00;
            rx_perr  <= 1'b0;
            rx_one   <= 1'b0;
          end
          else if (baud_tick)
            rx_tick <= rx_tick + 5'h01;
        uafd_pkg::S_DATA, uafd_pkg::S_PAR, uafd_pkg::S_STOP:
          if (rx_cent)
          begin
            rx_tick <= 5'h00;
            rx_one  <= rx_one | rx_s;
            if (rx_state == uafd_pkg::S_DATA)
            begin
              rx_data[rx_idx] <= rx_s;
              rx_idx          <= rx_idx + 3'h1;
              if (rx_idx == nbits_m1)
                rx_state <= par_en ? uafd_pkg::S_PAR : uafd_pkg::S_STOP;
            end
            else if (rx_state == uafd_pkg::S_PAR)
            begin
              rx_perr  <= rx_s != uafd_pkg::uafd_parity(rx_data, par_even);
              rx_state <= uafd_pkg::S_STOP;
            end
            else
              rx_state <= uafd_pkg::S_IDLE;
          end
          else if (baud_tick)
            rx_tick <= rx_tick + 5'h01;
        default: rx_state <= uafd_pkg::S_IDLE;
      endcase
    end
  end

  // Sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      overrun    <= 1'b0;
      thr_pend   <= 1'b0;
      thr_cond_d <= 1'b0;
      flow_pend  <= 1'b0;
      tout_cnt   <= 11'h000;
      tout_flag  <= 1'b0;
    end
    else
    begin
      thr_cond_d <= thr_cond;
      if (rx_end && rx_full)
        overrun <= 1'b1;
      else if (lsr_rd)
        overrun <= 1'b0;
      if (thr_cond && !thr_cond_d)
        thr_pend <= 1'b1;
      else if (tx_push || (isr_rd && isr_val == uafd_pkg::IS_THRE))
        thr_pend <= 1'b0;
      if (enh_feat[uafd_pkg::EF_ENH] &&
          ((int_en[uafd_pkg::IE_RTS] && next_rts_n && !rts_n) ||
           (int_en[uafd_pkg::IE_CTS] && cts_s && !cts_d)))
        flow_pend <= 1'b1;
      else if (isr_rd && isr_val == uafd_pkg::IS_FLOW)
        flow_pend <= 1'b0;
      // idle receiver with data times out
      if (rx_push || rx_pop || rx_cnt == '0)
        tout_cnt <= 11'h000;
      else if (baud_tick && !tout_flag)
        tout_cnt <= tout_cnt + 11'h001;
      if (baud_tick && !tout_flag && rx_cnt != '0 &&
          tout_cnt == tout_lim - 11'h001)
        tout_flag <= 1'b1;
      else if (rx_push || rx_pop)
        tout_flag <= 1'b0;
    end
  end

  always_comb
  begin
    if (!modem_ctl[uafd_pkg::MC_RTS])
      next_rts_n = 1'b1;
    else if (!rts_auto)
      next_rts_n = 1'b0;
    else if (!rts_n && rx_cnt >= rts_hi)
      next_rts_n = 1'b1;
    else if (rts_n && rx_cnt <= rts_lo)
      next_rts_n = 1'b0;
    else
      next_rts_n = rts_n;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rts_n <= 1'b1;
      irq   <= 1'b0;
    end
    else
    begin
      rts_n <= next_rts_n;
      irq   <= isr_val != uafd_pkg::IS_NONE;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_tx_start_low: assert property (
    tx_state == uafd_pkg::S_START |-> !txd) else $error("start not low");
  chk_tx_lsb_first: assert property (
    $rose(tx_state == uafd_pkg::S_DATA) |-> txd == tx_shift[0])
    else $error("first data bit not LSB");
  chk_tx_push_count: assert property (
    (tx_push && !tx_load && !fc_wr) |=> tx_cnt == $past(tx_cnt) + CW'(1))
    else $error("tx write did not advance");
  chk_tx_empty_flag: assert property (
    lsr_val[uafd_pkg::LS_TEMT] |-> (tx_cnt == '0 &&
                                   tx_state == uafd_pkg::S_IDLE))
    else $error("transmitter empty while busy");
  chk_start_reject: assert property (
    (rx_state == uafd_pkg::S_START && rx_half && rx_s)
    |=> rx_state == uafd_pkg::S_IDLE) else $error("false start kept");
  chk_rx_pop_ptr: assert property (
    (rx_pop && !fc_wr) |=> rx_rp == $past(rx_rp) + AW'(1))
    else $error("read did not pop");
  chk_tout_irq: assert property (
    (tout_flag && int_en[uafd_pkg::IE_RX]) |=> irq)
    else $error("timeout without interrupt");
  chk_rts_high: assert property (
    (rts_auto && !rts_n && rx_cnt >= rts_hi) |=> rts_n)
    else $error("rts not released at upper level");
  chk_rts_low: assert property (
    (rts_auto && rts_n && rx_cnt <= rts_lo) |=> !rts_n)
    else $error("rts not asserted at lower level");
  chk_cts_pause: assert property (
    (cts_hold && tx_state == uafd_pkg::S_IDLE) |=>
    tx_state == uafd_pkg::S_IDLE) else $error("sent while cts high");
endmodule // uafd_top

// ---- hw/uafd_pkg.sv ----
// Purpose: Shared constants for the UART FIFO data path
// Assumes: 32-bit AHB-Lite word registers, 8-bit data in low bits
// Notes:   Offsets are byte addresses of aligned words
package uafd_pkg;
  localparam logic [7:0] ADDR_DATA    = 8'h00;
  localparam logic [7:0] ADDR_INT_EN  = 8'h04;
  localparam logic [7:0] ADDR_INT_ST  = 8'h08;
  localparam logic [7:0] ADDR_FIFO    = 8'h0C;
  localparam logic [7:0] ADDR_LINE    = 8'h10;
  localparam logic [7:0] ADDR_MODEM   = 8'h14;
  localparam logic [7:0] ADDR_LSTAT   = 8'h18;
  localparam logic [7:0] ADDR_ENH     = 8'h1C;
  localparam logic [7:0] ADDR_FRAC    = 8'h20;

  localparam logic [7:0] REG_RESET    = 8'h00;

  // Interrupt enable bits
  localparam int IE_RX  = 0;
  localparam int IE_THR = 1;
  localparam int IE_RTS = 6;
  localparam int IE_CTS = 7;
  // Enhanced feature bits
  localparam int EF_ENH  = 4;
  localparam int EF_ARTS = 6;
  localparam int EF_ACTS = 7;
  // Modem control and fifo control bits
  localparam int MC_RTS   = 1;
  localparam int FC_EN    = 0;
  localparam int FC_RXRST = 1;
  localparam int FC_TXRST = 2;
  // Line control fields
  localparam int LC_STOP2 = 2;
  localparam int LC_PAR   = 3;
  localparam int LC_EVEN  = 4;
  // Line status bits
  localparam int LS_DR   = 0;
  localparam int LS_OVR  = 1;
  localparam int LS_TEMT = 6;

  // Interrupt status codes; priority is timeout, receive, holding empty, flow
  localparam logic [7:0] IS_NONE    = 8'h01;
  localparam logic [7:0] IS_THRE    = 8'h02;
  localparam logic [7:0] IS_RXRDY   = 8'h04;
  localparam logic [7:0] IS_TIMEOUT = 8'h0C;
  localparam logic [7:0] IS_FLOW    = 8'h20;

  localparam int          MIN_BITS   = 5;
  localparam logic [10:0] TOUT_CHARS = 11'h004;
  localparam logic [10:0] TOUT_BITS  = 11'h00C;

  // Indexed by two-bit selectors
  localparam logic [4:0] TRIG_LVL [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
  localparam logic [4:0] RTS_HI   [4] = '{5'h04, 5'h08, 5'h0E, 5'h0E};
  localparam logic [4:0] RTS_LO   [4] = '{5'h00, 5'h01, 5'h04, 5'h08};
  localparam logic [4:0] OS_TICKS [4] = '{5'h10, 5'h08, 5'h04, 5'h04};

  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_START = 5'b00010,
    S_DATA  = 5'b00100,
    S_PAR   = 5'b01000,
    S_STOP  = 5'b10000
  } uafd_ser_t;

  function automatic logic uafd_parity(input logic [7:0] d,
                                       input logic even);
    uafd_parity = even ? ^d : ~^d;
  endfunction
endpackage

// ---- hw/uafd_mem.sv ----
// Purpose: Small FIFO storage with registered read data
// Assumes: One write and one read port on one clock
// Notes:   Write-first on address match so a fresh head is seen
module uafd_mem #(
  parameter int WIDTH = 8,
  parameter int AW    = 4
) (
  input  wire logic             clk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  always_ff @(posedge clk)
  begin
    if (we && waddr == raddr)
      rdata <= wdata;
    else
      rdata <= mem[raddr];
  end
endmodule // uafd_mem

// ---- testbench/uafd_remote.sv ----
// Purpose: Remote UART partner, 8N1 at 16X
// Assumes: Shares clock and baud tick with the device
// Notes:   Starts a frame only while the device requests data
module uafd_remote (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       baud_tick,
  input  wire logic       go,
  input  wire logic [7:0] tx_byte,
  input  wire logic       dut_txd,
  input  wire logic       dut_rts_n,
  output logic            line_out,
  output logic            busy,
  output logic [7:0]      rx_byte,
  output int              n_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] tsh;
  logic [8:0] rsh;
  logic [4:0] ttk;
  logic [4:0] rtk;
  logic [3:0] tn;
  logic [3:0] rn;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      busy     <= 1'b0;
      line_out <= 1'b1;
    end
    else if (!busy && go && !dut_rts_n)
    begin
      busy     <= 1'b1;
      line_out <= 1'b0;
      tsh      <= {1'b1, tx_byte};
      tn       <= 4'h9;
      ttk      <= 5'h10;
    end
    else if (busy && baud_tick)
    begin
      ttk <= (ttk == 5'h01) ? 5'h10 : ttk - 5'h01;
      if (ttk == 5'h01)
      begin
        busy     <= (tn != 4'h0);
        line_out <= (tn == 4'h0) | tsh[0];
        tsh      <= tsh >> 1;
        tn       <= tn - 4'h1;
      end
    end
  // Centre sampling; no stop check
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      rn   <= 4'h0;
      n_rx <= 0;
    end
    else if (rn == 4'h0 && !dut_txd)
    begin
      rn  <= 4'hA;
      rtk <= 5'h08;
    end
    else if (rn != 4'h0 && baud_tick)
    begin
      rtk <= (rtk == 5'h01) ? 5'h10 : rtk - 5'h01;
      if (rtk == 5'h01)
      begin
        rsh <= {dut_txd, rsh[8:1]};
        rn  <= rn - 4'h1;
      end
      if (rtk == 5'h01 && rn == 4'h1)
      begin
        rx_byte <= rsh[8:1];
        n_rx    <= n_rx + 1;
      end
    end
endmodule // uafd_remote

// ---- testbench/uafd_top_tb_top.sv ----
// Purpose: Self-checking bench for the UART data path
// Assumes: Partner runs 8N1 at 16X
// Notes:   Tick every other clock keeps runs short
module uafd_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        baud_tick = 1'b0;
  logic        cts_n = 1'b0;
  logic        go = 1'b0;
  logic [7:0]  tx_byte = 8'h00;
  logic [31:0] hrdata, rd;
  logic [7:0]  rx_byte;
  logic [7:0]  q [$];
  logic        hready, hresp, txd, rxd, rts_n, irq, busy;
  int          n_rx, n_fail = 0, tests_run = 0, seed = 1, k;
  always #5 clk = ~clk;
  always @(posedge clk) baud_tick <= ~baud_tick;
  uafd_top u_dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .baud_tick(baud_tick), .rxd(rxd), .cts_n(cts_n), .txd(txd),
    .rts_n(rts_n), .irq(irq));
  uafd_remote u_remote (.clk(clk), .nrst(nrst), .baud_tick(baud_tick),
    .go(go), .tx_byte(tx_byte), .dut_txd(txd), .dut_rts_n(rts_n),
    .line_out(rxd), .busy(busy), .rx_byte(rx_byte), .n_rx(n_rx));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bail();
    n_fail++;
    end_of_test();
  endtask
  task automatic wait_rdy();
    int i;
    @(posedge clk);
    for (i = 0; hready !== 1'b1; i++)
    begin
      if (i > 50)
        bail();
      @(posedge clk);
    end
  endtask
  // Single word transfer; data phase follows accepted address phase
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wait_rx(input int n);
    int i;
    for (i = 0; i < 4000 && n_rx != n; i++)
      @(negedge clk);
    if (n_rx != n)
      bail();
  endtask
  task automatic wait_idle();
    int i;
    @(negedge clk);
    for (i = 0; i < 4000 && busy !== 1'b0; i++)
      @(negedge clk);
    if (busy !== 1'b0)
      bail();
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check({txd, rts_n, irq, hresp}, 4'hC);
    bus(1'b1, uafd_pkg::ADDR_LINE, 8'h03);
    bus(1'b1, uafd_pkg::ADDR_FIFO, 8'h01);
    bus(1'b1, uafd_pkg::ADDR_INT_EN, 8'h83);
    bus(1'b1, uafd_pkg::ADDR_ENH, 8'hD0);
    bus(1'b1, uafd_pkg::ADDR_MODEM, 8'h02);
    bus(1'b0, 8'h3C, 8'h00);
    check(rd, 32'h0);
    check(rts_n, 1'b0);
    for (k = 0; k < 4; k++)
    begin
      q.push_back(k == 0 ? 8'h80 : 8'($random(seed)));
      bus(1'b1, uafd_pkg::ADDR_DATA, q[k]);
    end
    bus(1'b0, uafd_pkg::ADDR_LSTAT, 8'h00);
    check(rd[6:5], 2'b00);
    for (k = 0; k < 4; k++)
    begin
      wait_rx(k + 1);
      check(rx_byte, q[k]);
    end
    for (k = 0; k < 300 && rd[6] !== 1'b1; k++)
      bus(1'b0, uafd_pkg::ADDR_LSTAT, 8'h00);
    check(rd[6:5], 2'b11);
    cts_n <= 1'b1;
    bus(1'b1, uafd_pkg::ADDR_DATA, 8'hA5);
    for (k = 0; k < 200; k++)
    begin
      @(negedge clk);
      check(txd, 1'b1);
    end
    @(posedge clk);
    cts_n <= 1'b0;
    wait_rx(5);
    check(rx_byte, 8'hA5);
    bus(1'b0, uafd_pkg::ADDR_INT_ST, 8'h00);
    check(rd, {24'h0, uafd_pkg::IS_THRE});
    bus(1'b0, uafd_pkg::ADDR_INT_ST, 8'h00);
    check(rd, {24'h0, uafd_pkg::IS_FLOW});
    bus(1'b1, uafd_pkg::ADDR_INT_EN, 8'h41);
    for (k = 0; k < 4; k++)
    begin
      q[k] = 8'($random(seed));
      @(posedge clk);
      tx_byte <= q[k];
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      wait_idle();
      check(irq, 1'b1);
    end
    check(rts_n, 1'b1);
    bus(1'b0, uafd_pkg::ADDR_LSTAT, 8'h00);
    check(rd[4:0], 5'h01);
    bus(1'b0, uafd_pkg::ADDR_INT_ST, 8'h00);
    check(rd, {24'h0, uafd_pkg::IS_RXRDY});
    repeat (1700) @(posedge clk);
    bus(1'b0, uafd_pkg::ADDR_INT_ST, 8'h00);
    check(rd, {24'h0, uafd_pkg::IS_TIMEOUT});
    for (k = 0; k < 4; k++)
    begin
      bus(1'b0, uafd_pkg::ADDR_DATA, 8'h00);
      check(rd, {24'h0, q[k]});
      @(negedge clk);
      check(rts_n, k < 3);
    end
    bus(1'b0, uafd_pkg::ADDR_INT_ST, 8'h00);
    check(rd, {24'h0, uafd_pkg::IS_FLOW});
    @(negedge clk);
    check(irq, 1'b0);
    end_of_test();
  end
endmodule // uafd_top_tb_top
